// >>> hdl/ams_cfg.svh
`ifndef AMS_CFG_SVH
`define AMS_CFG_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define AMS_MODE_ADDR 8'h21
`define AMS_SETUP_ADDR 8'h22
`define AMS_AVG_ADDR 8'h23

// ****************************************************************
// reset values and writable bits
// ****************************************************************
`define AMS_MODE_RST 8'h80
`define AMS_SETUP_RST 8'h00
`define AMS_AVG_RST 8'h00
`define AMS_MODE_WMASK 8'hF7
`define AMS_SETUP_WMASK 8'h33
`define AMS_AVG_WMASK 8'h0F
`define AMS_RDATA_NONE 8'h00

// ****************************************************************
// field positions
// ****************************************************************
`define AMS_FMT_BIT 7
`define AMS_PAD_BIT 6
`define AMS_RSVD_HI 5
`define AMS_RSVD_LO 4
`define AMS_SUB_BIT 2
`define AMS_OPM_HI 1
`define AMS_OPM_LO 0
`define AMS_REF_BIT 5
`define AMS_SCALE_BIT 4
`define AMS_ROUTE_HI 1
`define AMS_ROUTE_LO 0
`define AMS_WIN_HI 3
`define AMS_WIN_LO 0

// ****************************************************************
// field codes
// ****************************************************************
`define AMS_OPM_SAMPLE 2'h0
`define AMS_OPM_BURST 2'h1
`define AMS_OPM_AVG 2'h2
`define AMS_OPM_AUTO 2'h3
`define AMS_ROUTE_ANALOG 2'h0
`define AMS_ROUTE_HALF_VDD 2'h2
`define AMS_WIN_MAX_CODE 4'hB
`define AMS_RATIO_LOG2_MAX 4'hC

`endif

// >>> hdl/ams_pkg.sv
package ams_pkg;

  // ****************************************************************
  // operating modes entered on leaving configuration
  // ****************************************************************
  typedef enum logic [2:0] {
    AMS_RUN_SAMPLE,
    AMS_RUN_BURST_AVG,
    AMS_RUN_AVG,
    AMS_RUN_AUTO_MONITOR,
    AMS_RUN_AUTO_TRIGGER
  } ams_run_mode_type;

  // ****************************************************************
  // whole state of the register bank
  // ****************************************************************
  typedef struct packed {
    logic [7:0] mode_reg;
    logic [7:0] setup_reg;
    logic [7:0] avg_reg;
    logic [7:0] rdata;
    logic rd_valid;
    logic addr_err;
    logic wr_refused;
    logic in_cfg;
    ams_run_mode_type run_mode;
    logic signed_fmt;
    logic sign_pad;
    logic ref_vdd;
    logic scale_on;
    logic [1:0] route;
    logic route_ok;
    logic [3:0] ratio_log2;
  } ams_state_type;

endpackage : ams_pkg

// >>> hdl/ams_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface ams_link_if;
  import ams_pkg::*;

  logic [7:0] mode_reg;
  logic [7:0] setup_reg;
  logic [7:0] avg_reg;
  ams_run_mode_type chosen_mode;
  logic scale_on;
  logic route_ok;
  logic [3:0] ratio_log2;

  modport bank (
    output mode_reg, setup_reg, avg_reg,
    input chosen_mode, scale_on, route_ok, ratio_log2
  );
  modport dec (
    input mode_reg, setup_reg, avg_reg,
    output chosen_mode, scale_on, route_ok, ratio_log2
  );
endinterface : ams_link_if

`default_nettype wire

// >>> hdl/ams_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "ams_cfg.svh"

module ams_decode
  import ams_pkg::*;
(
  ams_link_if.dec link
);

  logic [1:0] opm;
  logic [1:0] route;
  logic [3:0] win;

  assign opm = link.mode_reg[`AMS_OPM_HI:`AMS_OPM_LO];
  assign route = link.setup_reg[`AMS_ROUTE_HI:`AMS_ROUTE_LO];
  assign win = link.avg_reg[`AMS_WIN_HI:`AMS_WIN_LO];

  always_comb begin
    unique case (opm)
      `AMS_OPM_SAMPLE: link.chosen_mode = AMS_RUN_SAMPLE;
      `AMS_OPM_BURST: link.chosen_mode = AMS_RUN_BURST_AVG;
      `AMS_OPM_AVG: link.chosen_mode = AMS_RUN_AVG;
      `AMS_OPM_AUTO: begin
        // sub-mode bit only matters here
        if (link.mode_reg[`AMS_SUB_BIT]) begin
          link.chosen_mode = AMS_RUN_AUTO_TRIGGER;
        end else begin
          link.chosen_mode = AMS_RUN_AUTO_MONITOR;
        end
      end
    endcase
  end

  // scaling only on the analog inputs
  assign link.scale_on = link.setup_reg[`AMS_SCALE_BIT] &&
    (route == `AMS_ROUTE_ANALOG);
  assign link.route_ok = (route == `AMS_ROUTE_ANALOG) ||
    (route == `AMS_ROUTE_HALF_VDD);

  // undefined codes saturate at the largest window
  assign link.ratio_log2 = (win > `AMS_WIN_MAX_CODE) ?
    `AMS_RATIO_LOG2_MAX : 4'(win + 4'h1);

endmodule : ams_decode

`default_nettype wire

// >>> hdl/ams_regs.sv
// Contract
// - mode bit 7 picks unsigned or signed results; resets signed.
// - bit 6 adds a sign-extension byte to read data when set.
// - sub-mode bit picks monitor or trigger, only in autonomous mode.
// - mode field: sample, burst avg, averaging, autonomous; resets sample.
// - reference bit selects reference pin at 0, supply at 1; resets 0.
// - scaling applies only with scale bit set and analog inputs routed.
// - route field: 0 analog inputs, 2 half supply; 1 and 3 invalid.
// - window field sets averaging ratio two to the power code plus one up to code 11; codes 12 to 15 saturate at code 11's ratio.
// - leaving configuration starts the mode from mode field and sub-mode.
`timescale 1ns/1ps
`default_nettype none
`include "ams_cfg.svh"

module ams_regs
  import ams_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // register access from the serial front end
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic rd_valid_o,
  output logic addr_err_o,
  output logic wr_refused_o,
  // configuration mode control
  input wire logic cfg_exit_i,
  input wire logic cfg_enter_i,
  output logic in_cfg_o,
  output ams_run_mode_type run_mode_o,
  // settings for the conversion datapath
  output logic signed_fmt_o,
  output logic sign_pad_byte_on_o,
  output logic ref_vdd_o,
  output logic monitored_result_scale_o,
  output logic [1:0] input_route_field_o,
  output logic input_route_ok_o,
  output logic [3:0] filter_window_size_log2_o
);

  // ****************************************************************
  // state and decoder
  // ****************************************************************
  ams_state_type s_q;
  ams_state_type s_d;

  ams_link_if link ();

  assign link.mode_reg = s_q.mode_reg;
  assign link.setup_reg = s_q.setup_reg;
  assign link.avg_reg = s_q.avg_reg;

  ams_decode u_decode (
    .link(link.dec)
  );

  logic hit_mode;
  logic hit_setup;
  logic hit_avg;
  logic hit_any;

  assign hit_mode = (addr_i == `AMS_MODE_ADDR);
  assign hit_setup = (addr_i == `AMS_SETUP_ADDR);
  assign hit_avg = (addr_i == `AMS_AVG_ADDR);
  assign hit_any = hit_mode || hit_setup || hit_avg;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    s_d.rd_valid = 1'b0;
    s_d.addr_err = 1'b0;
    s_d.wr_refused = 1'b0;

    // writes land only in configuration mode; reserved 5:4 stored as given
    if (wr_en_i) begin
      if (!hit_any) begin
        s_d.addr_err = 1'b1;
      end else if (!s_q.in_cfg) begin
        s_d.wr_refused = 1'b1;
      end else if (hit_mode) begin
        s_d.mode_reg = wdata_i & `AMS_MODE_WMASK;
      end else if (hit_setup) begin
        s_d.setup_reg = wdata_i & `AMS_SETUP_WMASK;
      end else begin
        s_d.avg_reg = wdata_i & `AMS_AVG_WMASK;
      end
    end

    // a read with a write in the same cycle sees the old value; an unmapped address raises one shared addr_err
    if (rd_en_i) begin
      s_d.rd_valid = 1'b1;
      if (hit_mode) begin
        s_d.rdata = s_q.mode_reg;
      end else if (hit_setup) begin
        s_d.rdata = s_q.setup_reg;
      end else if (hit_avg) begin
        s_d.rdata = s_q.avg_reg;
      end else begin
        s_d.rdata = `AMS_RDATA_NONE;
        s_d.addr_err = 1'b1;
      end
    end

    // the run mode is frozen from the registers at the exit command
    if (s_q.in_cfg && cfg_exit_i) begin
      s_d.in_cfg = 1'b0;
      s_d.run_mode = link.chosen_mode;
    end else if (!s_q.in_cfg && cfg_enter_i) begin
      s_d.in_cfg = 1'b1;
    end

    // settings follow the registers one cycle later
    s_d.signed_fmt = s_q.mode_reg[`AMS_FMT_BIT];
    s_d.sign_pad = s_q.mode_reg[`AMS_PAD_BIT];
    s_d.ref_vdd = s_q.setup_reg[`AMS_REF_BIT];
    s_d.scale_on = link.scale_on;
    s_d.route = s_q.setup_reg[`AMS_ROUTE_HI:`AMS_ROUTE_LO];
    s_d.route_ok = link.route_ok;
    s_d.ratio_log2 = link.ratio_log2;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q.mode_reg <= `AMS_MODE_RST;
      s_q.setup_reg <= `AMS_SETUP_RST;
      s_q.avg_reg <= `AMS_AVG_RST;
      s_q.rdata <= `AMS_RDATA_NONE;
      s_q.rd_valid <= 1'b0;
      s_q.addr_err <= 1'b0;
      s_q.wr_refused <= 1'b0;
      s_q.in_cfg <= 1'b1;
      s_q.run_mode <= AMS_RUN_SAMPLE;
      s_q.signed_fmt <= 1'b1;
      s_q.sign_pad <= 1'b0;
      s_q.ref_vdd <= 1'b0;
      s_q.scale_on <= 1'b0;
      s_q.route <= `AMS_ROUTE_ANALOG;
      s_q.route_ok <= 1'b1;
      s_q.ratio_log2 <= 4'h1;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign rdata_o = s_q.rdata;
  assign rd_valid_o = s_q.rd_valid;
  assign addr_err_o = s_q.addr_err;
  assign wr_refused_o = s_q.wr_refused;
  assign in_cfg_o = s_q.in_cfg;
  assign run_mode_o = s_q.run_mode;
  assign signed_fmt_o = s_q.signed_fmt;
  assign sign_pad_byte_on_o = s_q.sign_pad;
  assign ref_vdd_o = s_q.ref_vdd;
  assign monitored_result_scale_o = s_q.scale_on;
  assign input_route_field_o = s_q.route;
  assign input_route_ok_o = s_q.route_ok;
  assign filter_window_size_log2_o = s_q.ratio_log2;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence s_mode_wr;
    wr_en_i && hit_mode && in_cfg_o;
  endsequence

  sequence s_setup_wr;
    wr_en_i && hit_setup && in_cfg_o;
  endsequence

  sequence s_avg_wr;
    wr_en_i && hit_avg && in_cfg_o;
  endsequence

  sequence s_exit;
    in_cfg_o && cfg_exit_i;
  endsequence

  AST_FMT_FOLLOWS: assert property (
    s_mode_wr ##2 1'b1 |-> signed_fmt_o == $past(wdata_i[7], 2))
    else $error("result format does not follow written bit");

  AST_PAD_FOLLOWS: assert property (
    s_mode_wr ##2 1'b1 |-> sign_pad_byte_on_o == $past(wdata_i[6], 2))
    else $error("sign pad enable does not follow written bit");

  AST_RSVD_KEPT: assert property (
    s_mode_wr |=> s_q.mode_reg[5:4] == $past(wdata_i[5:4]))
    else $error("reserved mode bits not stored as written");

  AST_SUB_ONLY_AUTO: assert property (
    s_exit ##0 (s_q.mode_reg[1:0] != 2'h3) |=>
      run_mode_o != AMS_RUN_AUTO_MONITOR &&
      run_mode_o != AMS_RUN_AUTO_TRIGGER)
    else $error("autonomous sub-mode used outside autonomous mode");

  AST_SAMPLE_DECODE: assert property (
    s_exit ##0 (s_q.mode_reg[1:0] == 2'h0) |=>
      run_mode_o == AMS_RUN_SAMPLE)
    else $error("mode code 0 did not start sample mode");

  AST_TRIGGER_DECODE: assert property (
    s_exit ##0 (s_q.mode_reg[2:0] == 3'h7) |=>
      run_mode_o == AMS_RUN_AUTO_TRIGGER)
    else $error("autonomous trigger not entered");

  AST_REF_FOLLOWS: assert property (
    s_setup_wr ##2 1'b1 |-> ref_vdd_o == $past(wdata_i[5], 2))
    else $error("reference select does not follow written bit");

  // both ways: scaling must also come on when the gate is open
  AST_SCALE_GATE: assert property (
    monitored_result_scale_o == ($past(s_q.setup_reg[4]) &&
      $past(s_q.setup_reg[1:0]) == 2'h0))
    else $error("scaling does not follow scale bit and analog route");

  AST_ROUTE_VALID: assert property (
    s_setup_wr ##2 1'b1 |-> input_route_ok_o ==
      ($past(wdata_i[1:0], 2) == 2'h0 || $past(wdata_i[1:0], 2) == 2'h2))
    else $error("route validity wrong");

  AST_RATIO_CODE: assert property (
    s_avg_wr ##0 (wdata_i[3:0] <= 4'hB) ##2 1'b1 |->
      filter_window_size_log2_o == 4'($past(wdata_i[3:0], 2) + 4'h1))
    else $error("window exponent not code plus one");

  AST_RATIO_SAT: assert property (
    filter_window_size_log2_o <= 4'hC)
    else $error("window exponent above largest ratio");

  AST_RATIO_CLAMP: assert property (
    s_avg_wr ##0 (wdata_i[3:0] > 4'hB) ##2 1'b1 |->
      filter_window_size_log2_o == 4'hC)
    else $error("undefined window code not held at largest ratio");

  AST_EXIT_CFG: assert property (
    s_exit |=> !in_cfg_o ##1 (run_mode_o == $past(run_mode_o)))
    else $error("exit did not leave configuration mode");

endmodule : ams_regs

`default_nettype wire

// >>> tb/adc_mode_setup_registers_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "ams_cfg.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] t=%0t got %0h exp %0h", $time, (g), (e)); end end

module adc_mode_setup_registers_test import ams_pkg::*;;
  logic clk, rst_n, we, re, cx, ce;
  logic [7:0] ad, wd, rdata;
  logic rv, aerr, wref, in_cfg, sfmt, pad, refv, scl, rok;
  logic [1:0] route;
  logic [3:0] wlog;
  ams_run_mode_type rmode, rm_exp;
  logic [7:0] mdl [3];
  logic in_cfg_m;
  logic [9:0] exp_q [$];
  logic [7:0] a, d;
  logic [7:0] bad [4] = '{8'h00, 8'h20, 8'h24, 8'hFF};
  int num_errors, n_compared, cyc;

  ams_regs u_dut (
    .sys_clk_i(clk), .arst_n_i(rst_n), .wr_en_i(we), .rd_en_i(re),
    .addr_i(ad), .wdata_i(wd), .rdata_o(rdata), .rd_valid_o(rv),
    .addr_err_o(aerr), .wr_refused_o(wref), .cfg_exit_i(cx),
    .cfg_enter_i(ce), .in_cfg_o(in_cfg), .run_mode_o(rmode),
    .signed_fmt_o(sfmt), .sign_pad_byte_on_o(pad), .ref_vdd_o(refv),
    .monitored_result_scale_o(scl), .input_route_field_o(route),
    .input_route_ok_o(rok), .filter_window_size_log2_o(wlog)
  );

  // ****************************************************************
  // drivers and expectation model
  // ****************************************************************
  function automatic logic [7:0] wmask(input logic [7:0] x);
    case (x)
      `AMS_MODE_ADDR: return `AMS_MODE_WMASK;
      `AMS_SETUP_ADDR: return `AMS_SETUP_WMASK;
      default: return `AMS_AVG_WMASK;
    endcase
  endfunction : wmask

  // signals stay driven after return so that calls run back to back
  task automatic op(input logic w, r, input logic [7:0] x, y);
    logic ok;
    logic [1:0] i;
    ok = (x >= `AMS_MODE_ADDR) && (x <= `AMS_AVG_ADDR);
    i = x[1:0] - 2'h1;
    @(posedge clk);
    #1;
    we = w;
    re = r;
    ad = x;
    wd = y;
    if (r) exp_q.push_back(ok ? {2'h0, mdl[i]} : 10'h100);
    if (w && !ok && !r) exp_q.push_back(10'h100);
    if (w && ok && !in_cfg_m) exp_q.push_back(10'h200);
    if (w && ok && in_cfg_m) mdl[i] = y & wmask(x);
  endtask : op

  task automatic mode_cmd(input logic ex);
    op(1'b0, 1'b0, 8'h00, 8'h00);
    if (ex) cx = 1'b1;
    else ce = 1'b1;
    @(posedge clk);
    #1;
    cx = 1'b0;
    ce = 1'b0;
    in_cfg_m = !ex;
    case (mdl[0][1:0])
      `AMS_OPM_SAMPLE: rm_exp = AMS_RUN_SAMPLE;
      `AMS_OPM_BURST: rm_exp = AMS_RUN_BURST_AVG;
      `AMS_OPM_AVG: rm_exp = AMS_RUN_AVG;
      default: begin
        rm_exp = mdl[0][2] ? AMS_RUN_AUTO_TRIGGER : AMS_RUN_AUTO_MONITOR;
      end
    endcase
    @(posedge clk);
    #1;
    `CHK(in_cfg, in_cfg_m)
    if (ex) `CHK(rmode, rm_exp)
  endtask : mode_cmd

  task automatic chk_out;
    logic [1:0] r;
    logic [3:0] w;
    op(1'b0, 1'b0, 8'h00, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    r = mdl[1][1:0];
    w = mdl[2][3:0];
    `CHK(sfmt, mdl[0][7])
    `CHK(pad, mdl[0][6])
    `CHK(refv, mdl[1][5])
    `CHK(route, r)
    `CHK(rok, (r == 2'h0 || r == 2'h2))
    `CHK(scl, mdl[1][4] && r == 2'h0)
    `CHK(wlog, (w > 4'hB) ? 4'hC : w + 4'h1)
  endtask : chk_out

  task automatic do_reset;
    rst_n = 1'b0;
    mdl = '{`AMS_MODE_RST, `AMS_SETUP_RST, `AMS_AVG_RST};
    in_cfg_m = 1'b1;
    exp_q.delete();
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
  endtask : do_reset

  task automatic print_verdict;
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  // ****************************************************************
  // monitor, timeout and main sequence
  // ****************************************************************
  // pop once: the compare macro reads its expected argument twice
  task automatic pop(input logic [9:0] got);
    logic [9:0] want;
    if (exp_q.size() == 0) begin
      num_errors++;
      $display("[ERR] t=%0t got %0h exp none", $time, got);
    end else begin
      want = exp_q.pop_front();
      `CHK(got, want)
    end
  endtask : pop

  always @(posedge clk) begin
    cyc++;
    if (rst_n === 1'b1) begin
      if (aerr === 1'b1) pop(10'h100);
      else if (wref === 1'b1) pop(10'h200);
      else if (rv === 1'b1) pop({2'h0, rdata});
    end
    if (cyc == 6000) begin
      num_errors++;
      print_verdict();
    end
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    {we, re, cx, ce, ad, wd} = '0;
    void'($urandom(96));
    do_reset();
    for (int i = 1; i < 4; i++) op(1'b0, 1'b1, 8'h20 + 8'(i), 8'h00);
    chk_out();
    mode_cmd(1'b1);
    mode_cmd(1'b0);
    repeat (12) begin
      a = 8'h21 + 8'($urandom_range(2));
      d = 8'($urandom);
      if (a == `AMS_MODE_ADDR) d[5:4] = 2'h0;
      op(1'b1, 1'b0, a, d);
      op(1'b0, 1'b1, a, 8'h00);
    end
    op(1'b1, 1'b1, 8'h23, 8'h0A);
    chk_out();
    for (int i = 0; i < 16; i++) begin
      op(1'b1, 1'b0, 8'h23, {4'($urandom), 4'(i)});
      op(1'b1, 1'b0, 8'h22, {2'b11, i[0], i[1], 2'b11, i[3:2]});
      chk_out();
    end
    for (int i = 0; i < 8; i++) begin
      op(1'b1, 1'b0, 8'h21, {2'($urandom), 3'b001, 3'(i)});
      chk_out();
      mode_cmd(1'b1);
      op(1'b1, 1'b0, 8'h22, 8'h21);
      op(1'b0, 1'b1, 8'h22, 8'h00);
      mode_cmd(1'b0);
    end
    foreach (bad[i]) begin
      op(1'b1, 1'b0, bad[i], 8'h5A);
      op(1'b0, 1'b1, bad[i], 8'h00);
    end
    op(1'b0, 1'b0, 8'h00, 8'h00);
    repeat (3) @(posedge clk);
    #1;
    do_reset();
    op(1'b0, 1'b1, 8'h21, 8'h00);
    chk_out();
    `CHK(in_cfg, 1'b1)
    `CHK(rmode, AMS_RUN_SAMPLE)
    repeat (4) @(posedge clk);
    `CHK(exp_q.size(), 0)
    print_verdict();
  end
endmodule : adc_mode_setup_registers_test

`default_nettype wire
